//--- rtl/core_seq_pkg.sv
// Package: constants and types for the core sequencer, clock select and watchdog
package core_seq_pkg;
    localparam logic [31:0] OSC_CONTROL_ADDR   = 32'h0000_0008;
    localparam logic [31:0] PC_CONTROL_ADDR    = 32'h0000_000c;
    localparam logic [31:0] WDT_CONTROL_ADDR   = 32'h0000_0010;
    localparam logic [31:0] STATUS_ADDR        = 32'h0000_0014;
    localparam int          WDT_EN_BIT         = 7;
    localparam int          CLK_SEL_LSB        = 4;
    localparam int          TIMER_ZERO_EN_BIT        = 0;
    localparam logic [7:0]  OSC_CONTROL_RESET  = 8'he0;
    localparam logic [7:0]  OSC_CONTROL_MASK   = 8'hf1;
    localparam int          PC_W               = 10;
    localparam logic [9:0]  RESET_VECTOR       = 10'h000;
    localparam logic [9:0]  INT_VECTOR         = 10'h004;
    localparam int          FOSC_HZ            = 8_000_000;
    localparam int          FWDT_HZ            = 8_000;
    localparam int          CLK_HZ             = 200_000_000;
    localparam int          FOSC_DIV           = CLK_HZ / FOSC_HZ;
    localparam int          FWDT_DIV           = CLK_HZ / FWDT_HZ;
    localparam int          WDT_PERIOD_MS      = 18;
    localparam int          WDT_BASE_TICKS     = WDT_PERIOD_MS * FWDT_HZ / 1000;
    localparam int          PHASES             = 4;
    localparam logic [2:0]  CLK_SEL_WDT        = 3'h0;
    localparam logic [2:0]  CLK_SEL_FOSC1      = 3'h7;
    localparam logic [6:0]  PRESCALE_MAX       = 7'h7f;

    typedef enum logic [2:0] {
        OP_NONE, OP_JUMP, OP_COND_JUMP, OP_CALL, OP_RETURN, OP_PCL_WRITE, OP_WATCHDOG_CLEAR_INSTR, OP_STOP
    } op_kind_t;

    typedef struct packed {
        op_kind_t           kind;
        logic               taken;
        logic [PC_W-1:0]    target;
        logic [7:0]         pcl_value;
    } instr_ev_t;

    typedef struct packed {
        logic               psel;
        logic               penable;
        logic               pwrite;
        logic [31:0]        paddr;
        logic [31:0]        pwdata;
    } apb_req_t;
endpackage : core_seq_pkg

//--- rtl/core_sequencer_clock_watchdog.sv
// Core sequencer: program counter, phase clock, clock select, watchdog
// Function
// R1 - PC increments by one after each fetch unless a transfer loads another address
// R2 - Jumps, calls, returns, interrupts and low-byte writes load their own address
// R3 - Taken conditional jump discards prefetch and inserts one empty cycle
// R4 - Reset sets PC to 0000; interrupt pushes PC+1 and loads 0004
// R5 - Low-byte write loads PC[7:0] from data and PC[9:8] from high latch
// R6 - Four phases per instruction cycle; phase one increments, phase four fetches
// R7 - Fetch overlaps execute; PC-changing instructions take two cycles
// R8 - Watchdog runs from its own oscillator tick even when core clock stops
// R9 - Watchdog overflow produces a chip reset
// R10 - Watchdog off only when configuration option and soft enable are both off
// R11 - Base overflow 18 ms; prescaler 1:128 stretches it to about 2.3 s
// R12 - Clear and stop instructions zero watchdog and its prescaler when assigned
// R13 - Watchdog reset clears the timeout flag
// R14 - Software clears the watchdog from the main path, not from handlers
// R15 - Main oscillator is internal RC at nominal 8 MHz
// R16 - Control bit 7 enables the watchdog, reset value 1
// R17 - Bits 6..4 choose core clock: watchdog osc or main osc divided 64..1
// R18 - Control bit 0 enables timer zero, reset value 0
// R19 - At 8 MHz one-cycle instruction takes 500 ns, two-cycle 1 us
// R20 - One shared prescaler serves timer zero or watchdog, ratio 1:1 to 1:128
// R21 - Phase generator is clocked by the selected core clock
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
module core_sequencer_clock_watchdog
    import core_seq_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_rstn,
    input  wire logic               i_psel,
    input  wire logic               i_penable,
    input  wire logic               i_pwrite,
    input  wire logic [31:0]        i_paddr,
    input  wire logic [31:0]        i_pwdata,
    output logic      [31:0]        o_prdata,
    output logic                    o_pready,
    output logic                    o_pslverr,
    input  wire logic               i_cfg_wdt_enable,
    input  wire logic               i_instr_valid,
    input  wire instr_ev_t          i_instr,
    input  wire logic               i_irq,
    input  wire logic [PC_W-1:0]    i_stack_top,
    input  wire logic               i_prescaler_assign,
    input  wire logic [2:0]         i_prescale_sel,
    output logic      [PC_W-1:0]    o_pc,
    output logic      [PC_W-1:0]    o_push_value,
    output logic                    o_push,
    output logic      [1:0]         o_phase,
    output logic                    o_fetch,
    output logic                    o_exec_valid,
    output logic                    o_core_tick,
    output logic                    o_timer0_enable,
    output logic                    o_chip_reset,
    output logic                    o_timeout_flag,
    output logic                    o_sleeping
);
    localparam int          WDT_CNT_W = $clog2(WDT_BASE_TICKS + 1);
    localparam logic [WDT_CNT_W-1:0] WDT_LAST = WDT_CNT_W'(WDT_BASE_TICKS - 1);

    typedef enum logic [1:0] {SEQ_RUN, SEQ_FLUSH, SEQ_SLEEP} seq_state_t;

    function automatic logic [6:0] div_last(input logic [2:0] sel);
        case (sel)
            3'h1:    div_last = 7'h3f;
            3'h2:    div_last = 7'h1f;
            3'h3:    div_last = 7'h0f;
            3'h4:    div_last = 7'h07;
            3'h5:    div_last = 7'h03;
            3'h6:    div_last = 7'h01;
            default: div_last = 7'h00;
        endcase
    endfunction : div_last

    function automatic logic [6:0] prescale_last(input logic [2:0] sel);
        prescale_last = 7'((8'h01 << sel) - 8'h01);
    endfunction : prescale_last

    logic                   rst_meta_r;
    logic                   rst_sync_r;
    logic                   rst_n;
    logic                   wdt_rst_r;
    logic [7:0]             osc_control_r;
    logic [1:0]             pc_high_latch_r;
    logic [PC_W-1:0]        pc_r;
    logic [PC_W-1:0]        pc_nxt;
    logic [1:0]             phase_r;
    seq_state_t             state_r;
    logic [7:0]             fosc_cnt_r;
    logic                   fosc_tick;
    logic [15:0]            fwdt_cnt_r;
    logic                   fwdt_tick;
    logic [6:0]             core_div_r;
    logic                   core_tick;
    logic [WDT_CNT_W-1:0]   wdt_cnt_r;
    logic [6:0]             wdt_pre_r;
    logic                   wdt_active;
    logic                   wdt_clear;
    logic                   wdt_overflow;
    logic                   timeout_r;
    logic                   apb_access;
    logic                   transfer;

    // Reset release through two stages
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign rst_n = rst_sync_r & ~wdt_rst_r;

    // Main RC oscillator and watchdog oscillator ticks
    always_ff @(posedge i_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            fosc_cnt_r <= 8'h00;
            fwdt_cnt_r <= 16'h0000;
        end else begin
            fosc_cnt_r <= fosc_tick ? 8'h00 : fosc_cnt_r + 8'h01; // see R15
            fwdt_cnt_r <= fwdt_tick ? 16'h0000 : fwdt_cnt_r + 16'h0001; // see R8
        end
    end
    assign fosc_tick = fosc_cnt_r == 8'(FOSC_DIV - 1); // see R15 R19
    assign fwdt_tick = fwdt_cnt_r == 16'(FWDT_DIV - 1);

    // Core clock divider chosen by the select field
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            core_div_r <= 7'h00;
        end else if (osc_control_r[CLK_SEL_LSB +: 3] != CLK_SEL_WDT && fosc_tick) begin
            core_div_r <= (core_div_r >= div_last(osc_control_r[CLK_SEL_LSB +: 3]))
                          ? 7'h00 : core_div_r + 7'h01; // see R17
        end
    end
    assign core_tick = (osc_control_r[CLK_SEL_LSB +: 3] == CLK_SEL_WDT) ? fwdt_tick
                     : fosc_tick
                       && core_div_r >= div_last(osc_control_r[CLK_SEL_LSB +: 3]); // see R17

    // APB register access
    assign apb_access = i_psel && i_penable;
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            osc_control_r   <= OSC_CONTROL_RESET; // see R16 R18
            pc_high_latch_r <= 2'h0;
            o_prdata        <= 32'h0000_0000;
            o_pready        <= 1'b0;
            o_pslverr       <= 1'b0;
        end else begin
            o_pready  <= i_psel && !i_penable;
            o_pslverr <= 1'b0;
            if (i_psel && !i_penable) begin
                o_prdata <= 32'h0000_0000;
                case (i_paddr)
                    OSC_CONTROL_ADDR: o_prdata <= {24'h0, osc_control_r};
                    PC_CONTROL_ADDR:  o_prdata <= {20'h0, pc_high_latch_r, pc_r};
                    STATUS_ADDR:      o_prdata <= {27'h0, state_r == SEQ_SLEEP,
                                                   timeout_r, phase_r, wdt_active};
                    WDT_CONTROL_ADDR: o_prdata <= {25'h0, wdt_pre_r};
                    default:          o_pslverr <= 1'b1;
                endcase
                if (i_paddr != OSC_CONTROL_ADDR && i_paddr != PC_CONTROL_ADDR
                    && i_paddr != STATUS_ADDR && i_paddr != WDT_CONTROL_ADDR) begin
                    o_pslverr <= 1'b1;
                end else begin
                    o_pslverr <= 1'b0;
                end
            end
            if (apb_access && o_pready && i_pwrite) begin
                if (i_paddr == OSC_CONTROL_ADDR) begin
                    osc_control_r <= i_pwdata[7:0] & OSC_CONTROL_MASK; // see R16 R17 R18
                end
                if (i_paddr == PC_CONTROL_ADDR) begin
                    pc_high_latch_r <= i_pwdata[PC_W+1:PC_W]; // see R5
                end
            end
        end
    end

    // Control transfer decode
    assign transfer = i_instr_valid && (i_instr.kind == OP_JUMP || i_instr.kind == OP_CALL
                   || i_instr.kind == OP_RETURN || i_instr.kind == OP_PCL_WRITE
                   || (i_instr.kind == OP_COND_JUMP && i_instr.taken)); // see R2 R3 R7

    always_comb begin
        pc_nxt = pc_r + 10'h001; // see R1
        if (i_irq) begin
            pc_nxt = INT_VECTOR; // see R4
        end else if (transfer) begin
            case (i_instr.kind)
                OP_RETURN:    pc_nxt = i_stack_top; // see R2
                OP_PCL_WRITE: pc_nxt = {pc_high_latch_r, i_instr.pcl_value}; // see R5
                default:      pc_nxt = i_instr.target; // see R2
            endcase
        end
    end

    // Four-phase sequencer on the core clock
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_r         <= RESET_VECTOR; // see R4
            phase_r      <= 2'h0;
            state_r      <= SEQ_RUN;
            o_fetch      <= 1'b0;
            o_exec_valid <= 1'b0;
            o_push       <= 1'b0;
            o_push_value <= RESET_VECTOR;
        end else begin
            o_fetch <= 1'b0;
            o_push  <= 1'b0;
            if (core_tick && state_r != SEQ_SLEEP) begin
                phase_r <= phase_r + 2'h1; // see R6 R21
                if (phase_r == 2'(PHASES - 1)) begin
                    o_fetch <= 1'b1; // see R6
                    case (state_r)
                        SEQ_RUN: begin
                            o_exec_valid <= !(transfer || i_irq); // see R3 R7
                            if (i_irq) begin
                                o_push       <= 1'b1;
                                o_push_value <= pc_r + 10'h001; // see R4
                            end
                            if (transfer || i_irq) begin
                                pc_r    <= pc_nxt;
                                state_r <= SEQ_FLUSH; // see R3 R7
                            end else if (i_instr_valid && i_instr.kind == OP_STOP) begin
                                state_r <= SEQ_SLEEP;
                            end
                        end
                        SEQ_FLUSH: begin
                            o_exec_valid <= 1'b1; // see R3
                            state_r      <= SEQ_RUN;
                        end
                        default: state_r <= SEQ_RUN;
                    endcase
                end else if (phase_r == 2'h0 && state_r == SEQ_RUN) begin
                    pc_r <= pc_r + 10'h001; // see R1 R6
                end
            end
        end
    end

    // Watchdog counter and prescaler
    assign wdt_active   = i_cfg_wdt_enable || osc_control_r[WDT_EN_BIT]; // see R10
    assign wdt_clear    = i_instr_valid && core_tick && phase_r == 2'(PHASES - 1)
                       && state_r == SEQ_RUN
                       && (i_instr.kind == OP_WATCHDOG_CLEAR_INSTR || i_instr.kind == OP_STOP); // see R12
    assign wdt_overflow = wdt_active && fwdt_tick && wdt_cnt_r == WDT_LAST
                       && (!i_prescaler_assign || wdt_pre_r >= prescale_last(i_prescale_sel));
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdt_cnt_r <= '0;
            wdt_pre_r <= 7'h00;
        end else if (wdt_clear) begin
            wdt_cnt_r <= '0; // see R12
            if (i_prescaler_assign) begin
                wdt_pre_r <= 7'h00; // see R12 R20
            end
        end else if (wdt_active && fwdt_tick) begin
            wdt_cnt_r <= (wdt_cnt_r == WDT_LAST) ? '0
                         : wdt_cnt_r + WDT_CNT_W'(1); // see R8 R11
            if (wdt_cnt_r == WDT_LAST && i_prescaler_assign) begin
                wdt_pre_r <= (wdt_pre_r >= prescale_last(i_prescale_sel))
                             ? 7'h00 : wdt_pre_r + 7'h01; // see R11 R20
            end
        end
    end

    // Overflow reset pulse and timeout flag survive the chip reset
    always_ff @(posedge i_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            wdt_rst_r <= 1'b0;
            timeout_r <= 1'b1;
        end else begin
            wdt_rst_r <= wdt_overflow; // see R9
            if (wdt_overflow) begin
                timeout_r <= 1'b0; // see R13
            end else if (wdt_clear) begin
                timeout_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            o_chip_reset    <= 1'b0;
            o_timeout_flag  <= 1'b1;
            o_timer0_enable <= 1'b0;
            o_core_tick     <= 1'b0;
            o_pc            <= RESET_VECTOR;
            o_phase         <= 2'h0;
            o_sleeping      <= 1'b0;
        end else begin
            o_chip_reset    <= wdt_rst_r; // see R9
            o_timeout_flag  <= timeout_r;
            o_timer0_enable <= osc_control_r[TIMER_ZERO_EN_BIT]; // see R18
            o_core_tick     <= core_tick;
            o_pc            <= pc_r;
            o_phase         <= phase_r;
            o_sleeping      <= state_r == SEQ_SLEEP;
        end
    end
endmodule : core_sequencer_clock_watchdog

//--- verification/core_seq_properties.sv
// Checker: sequencer, phase, watchdog timeout and register bus properties
`timescale 1ns/10ps
module core_seq_properties
    import core_seq_pkg::*;
(
    input wire logic            i_clk,
    input wire logic            i_rstn,
    input wire logic            i_psel,
    input wire logic            i_penable,
    input wire logic            i_pwrite,
    input wire logic [31:0]     i_paddr,
    input wire logic [31:0]     i_pwdata,
    input wire logic            o_pready,
    input wire logic            i_instr_valid,
    input wire instr_ev_t       i_instr,
    input wire logic            i_irq,
    input wire logic [PC_W-1:0] i_stack_top,
    input wire logic [PC_W-1:0] o_pc,
    input wire logic [PC_W-1:0] o_push_value,
    input wire logic            o_push,
    input wire logic [1:0]      o_phase,
    input wire logic            o_fetch,
    input wire logic            o_exec_valid,
    input wire logic            o_core_tick,
    input wire logic            o_timer0_enable,
    input wire logic            o_chip_reset,
    input wire logic            o_timeout_flag,
    input wire logic            o_sleeping
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rstn || o_chip_reset);
    wire logic take = o_core_tick && o_phase == 2'd3 && !i_irq && i_instr_valid;
    a_jump_load: assert property (take && i_instr.kind == OP_JUMP |=>
        o_pc == $past(i_instr.target)) else $error("jump target not loaded");
    a_return_load: assert property (take && i_instr.kind == OP_RETURN |=>
        o_pc == $past(i_stack_top)) else $error("return address not loaded");
    a_cond_flush: assert property (take && i_instr.kind == OP_COND_JUMP && i_instr.taken
        |=> o_pc == $past(i_instr.target) && !o_exec_valid) else $error("taken branch not flushed");
    a_low_byte: assert property (take && i_instr.kind == OP_PCL_WRITE |=>
        o_pc[7:0] == $past(i_instr.pcl_value)) else $error("low byte write wrong");
    a_irq_vector: assert property (o_core_tick && o_phase == 2'd3 && i_irq |->
        o_push ##1 (o_pc == INT_VECTOR && o_push_value == $past(o_pc) + 10'd1))
        else $error("interrupt entry wrong");
    a_phase_step: assert property (o_core_tick && !o_sleeping |=>
        o_phase == $past(o_phase) + 2'd1) else $error("phase did not advance");
    a_phase_hold: assert property (!o_core_tick |=> $stable(o_phase))
        else $error("phase moved without core tick");
    a_fetch_pulse: assert property (o_fetch == (o_core_tick && o_phase == 2'd3))
        else $error("fetch pulse misplaced");
    a_timer0_write: assert property (i_psel && i_penable && o_pready && i_pwrite
        && i_paddr == OSC_CONTROL_ADDR |-> ##2 o_timer0_enable == $past(i_pwdata[0], 2))
        else $error("timer zero enable not written");
    a_timeout_clear: assert property (disable iff (!i_rstn) o_chip_reset |->
        ##[0:2] !o_timeout_flag) else $error("timeout flag not cleared");
endmodule : core_seq_properties

bind core_sequencer_clock_watchdog core_seq_properties u_core_seq_properties (
    .i_clk, .i_rstn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready,
    .i_instr_valid, .i_instr, .i_irq, .i_stack_top, .o_pc, .o_push_value, .o_push, .o_phase,
    .o_fetch, .o_exec_valid, .o_core_tick, .o_timer0_enable, .o_chip_reset, .o_timeout_flag,
    .o_sleeping);

//--- verification/test_core_sequencer_clock_watchdog.sv
// Testbench: register bus, clock select and program counter sequences
`timescale 1ns/10ps
module test_core_sequencer_clock_watchdog
    import core_seq_pkg::*;
;
    logic        i_clk, i_rstn, psel, penable, pwrite, cfg_en, ivalid, irq, push, sleeping;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic        pready, pslverr, err, fetch, exec_valid, tick, t0_en, timeout, push_seen;
    instr_ev_t   instr;
    logic [9:0]  stack_top, pc, push_val, pc_seen, p;
    logic [1:0]  phase;
    int          n_fail, cmp_count, n, exp_n;

    core_sequencer_clock_watchdog u_core_sequencer_clock_watchdog (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_cfg_wdt_enable(cfg_en),
        .i_instr_valid(ivalid), .i_instr(instr), .i_irq(irq), .i_stack_top(stack_top),
        .i_prescaler_assign(1'b1), .i_prescale_sel(3'h7), .o_pc(pc), .o_push_value(push_val),
        .o_push(push), .o_phase(phase), .o_fetch(fetch), .o_exec_valid(exec_valid),
        .o_core_tick(tick), .o_timer0_enable(t0_en), .o_chip_reset(), .o_timeout_flag(timeout),
        .o_sleeping(sleeping));

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : stop_test

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        @(posedge i_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge i_clk);
        penable <= 1'b1;
        do @(posedge i_clk); while (pready !== 1'b1);
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task automatic step(input op_kind_t k, input logic tk, input logic [9:0] tg,
                        input logic [7:0] pv, input logic rq);
        wait_tick();
        ivalid <= (k != OP_NONE); instr <= '{k, tk, tg, pv}; irq <= rq;
        do @(posedge i_clk); while (!(tick === 1'b1 && phase === 2'd3));
        pc_seen = pc;
        push_seen = push;
        ivalid <= 1'b0; irq <= 1'b0;
        #1;
    endtask : step

    task automatic wait_tick;
        do @(posedge i_clk); while (tick !== 1'b1);
    endtask : wait_tick

    initial begin
        repeat (100000) @(posedge i_clk);
        n_fail++;
        stop_test();
    end

    initial begin
        n_fail = 0; cmp_count = 0; i_rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = '0; pwdata = '0; cfg_en = 1'b1; ivalid = 1'b0; instr = '0; irq = 1'b0;
        stack_top = 10'h321;
        repeat (16) @(posedge i_clk);
        i_rstn <= 1'b1;
        repeat (4) @(posedge i_clk);
        check("pc", 32'(RESET_VECTOR), 32'(pc));
        apb(1'b0, OSC_CONTROL_ADDR, '0);
        check("osc reset", 32'h0000_00e0, rd);
        apb(1'b1, OSC_CONTROL_ADDR, 32'h0000_00ff);
        apb(1'b0, OSC_CONTROL_ADDR, '0);
        check("osc masked", 32'h0000_00f1, rd);
        check("timer0 en", 32'h1, 32'(t0_en));
        apb(1'b0, 32'h0000_0040, '0);
        check("unmapped err", 32'h1, 32'(err));
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, OSC_CONTROL_ADDR, {24'h0, 1'b1, c[2:0], 4'h0});
            exp_n = (c == 0) ? FWDT_DIV : FOSC_DIV * (64 >> (c - 1));
            wait_tick();
            n = 0;
            do begin @(posedge i_clk); n++; end while (tick !== 1'b1 && n < 60000);
            check("tick spacing", 32'(exp_n), 32'(n));
        end
        check("timer0 off", 32'h0, 32'(t0_en));
        do @(posedge i_clk); while (fetch !== 1'b1);
        p = pc;
        @(posedge i_clk);
        do @(posedge i_clk); while (fetch !== 1'b1);
        check("pc advance", 32'(p + 10'd1), 32'(pc));
        apb(1'b1, PC_CONTROL_ADDR, 32'h0000_0800);
        step(OP_PCL_WRITE, 1'b0, 10'h0, 8'h34, 1'b0);
        check("pc low write", 32'h234, 32'(pc));
        check("flush", 32'h0, 32'(exec_valid));
        step(OP_NONE, 1'b0, 10'h0, 8'h0, 1'b0);
        step(OP_JUMP, 1'b0, 10'h155, 8'h0, 1'b0);
        check("pc jump", 32'h155, 32'(pc));
        step(OP_NONE, 1'b0, 10'h0, 8'h0, 1'b0);
        step(OP_COND_JUMP, 1'b1, 10'h2aa, 8'h0, 1'b0);
        check("pc cond taken", 32'h2aa, 32'(pc));
        check("cond flush", 32'h0, 32'(exec_valid));
        step(OP_NONE, 1'b0, 10'h0, 8'h0, 1'b0);
        step(OP_COND_JUMP, 1'b0, 10'h0aa, 8'h0, 1'b0);
        check("pc cond not taken", 32'(pc_seen), 32'(pc));
        check("no flush", 32'h1, 32'(exec_valid));
        step(OP_RETURN, 1'b0, 10'h0, 8'h0, 1'b0);
        check("pc return", 32'h321, 32'(pc));
        step(OP_NONE, 1'b0, 10'h0, 8'h0, 1'b0);
        step(OP_NONE, 1'b0, 10'h0, 8'h0, 1'b1);
        check("pc irq", 32'(INT_VECTOR), 32'(pc));
        check("push value", 32'(pc_seen + 10'd1), 32'(push_val));
        check("push", 32'h1, 32'(push_seen));
        step(OP_NONE, 1'b0, 10'h0, 8'h0, 1'b0);
        for (int c = 0; c < 4; c++) begin
            cfg_en <= c[0];
            apb(1'b1, OSC_CONTROL_ADDR, {24'h0, c[1], 7'h70});
            apb(1'b0, STATUS_ADDR, '0);
            check("wdt active", 32'(c[0] | c[1]), {31'h0, rd[0]});
        end
        step(OP_WATCHDOG_CLEAR_INSTR, 1'b0, 10'h0, 8'h0, 1'b0);
        apb(1'b0, WDT_CONTROL_ADDR, '0);
        check("prescale cleared", 32'h0, rd);
        check("timeout flag", 32'h1, 32'(timeout));
        step(OP_STOP, 1'b0, 10'h0, 8'h0, 1'b0);
        check("sleeping", 32'h1, 32'(sleeping));
        stop_test();
    end
endmodule : test_core_sequencer_clock_watchdog
